// ==== hdl/sram_ctrl_pkg.sv ====
package sram_ctrl_pkg;

  // ==========================================================================
  // Geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;

  // ==========================================================================
  // Timing, figures in ns (recovery in ms) and counts at the 20 MHz clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_CYCLE_NS = 40;
  localparam int T_SELECT_TO_END_NS = 35;
  localparam int T_ACCESS_NS = 40;
  localparam int T_RELEASE_NS = 20;
  localparam int T_RECOVERY_MS = 5;
  localparam int NS_PER_MS = 1000000;

  // Least times round up, none below one cycle.
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CYC_WRITE = ceil_cycles(T_SELECT_TO_END_NS);
  localparam int CYC_READ = ceil_cycles(T_ACCESS_NS);
  localparam int CYC_RELEASE = ceil_cycles(T_RELEASE_NS);
  localparam int CYC_RECOVERY = ceil_cycles(T_RECOVERY_MS * NS_PER_MS);
  localparam int CNT_W = 17;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] lane_en;
  } req_s;

  typedef struct packed {
    logic select_active_low;
    logic select_active_high;
    logic output_enable_n;
    logic read_write;
    logic low_byte_enable_n;
    logic upper_byte_enable_n;
  } ctrl_s;

  localparam ctrl_s CTRL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ==== hdl/sram_host.sv ====
`timescale 1ns/1ps
// Contract
// - Read: write-high, selected, output enable low
// - Never drive data while device drives
// - Each cycle lasts at least 40 ns
// - Select held 35 ns before write end
// - Byte enable held 35 ns before end
// - Wait 5 ms after retention before access
module sram_host #(
  parameter int RECOVERY_CYCLES = sram_ctrl_pkg::CYC_RECOVERY
) (
  input wire logic clk,
  input wire logic rst_n,
  // Request side
  input wire logic req_valid,
  input wire sram_ctrl_pkg::req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [sram_ctrl_pkg::DATA_W-1:0] rsp_rdata,
  // Retention control
  input wire logic retain,
  output logic retained,
  // Memory pins
  output logic [sram_ctrl_pkg::ADDR_W-1:0] word_address,
  output sram_ctrl_pkg::ctrl_s ctrl,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] data_in,
  output logic [sram_ctrl_pkg::DATA_W-1:0] data_out,
  output logic [sram_ctrl_pkg::LANES-1:0] data_oe
);

  typedef enum logic [2:0] {ST_RECOVER, ST_IDLE, ST_WRITE, ST_WEND, ST_READ, ST_REND, ST_RETAIN} state_e;

  state_e state_q;
  logic [sram_ctrl_pkg::CNT_W-1:0] cnt_q;
  logic [sram_ctrl_pkg::DATA_W-1:0] sync1_q;
  logic [sram_ctrl_pkg::DATA_W-1:0] sync2_q;
  logic retain_s1_q;
  logic retain_s2_q;
  logic take;
  logic write_done;
  logic read_done;
  logic [sram_ctrl_pkg::LANES-1:0] lanes_q;
  wire logic [sram_ctrl_pkg::DATA_W-1:0] lane_mask;

  assign take = req_ready && req_valid;
  assign write_done = (state_q == ST_WRITE) && (cnt_q >= sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::CYC_WRITE - 1));
  assign read_done = (state_q == ST_READ) && (cnt_q >= sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::CYC_READ + 1));

  // ==========================================================================
  // Input synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= data_in;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      retain_s1_q <= 1'b0;
      retain_s2_q <= 1'b0;
    end else begin
      retain_s1_q <= retain;
      retain_s2_q <= retain_s1_q;
    end
  end

  // ==========================================================================
  // Sequencer
  // Every phase lasts whole 50 ns clocks, so 40 ns cycle minimums are met with margin.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RECOVER;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ST_RECOVER: begin
          if (cnt_q >= sram_ctrl_pkg::CNT_W'(RECOVERY_CYCLES - 1)) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_IDLE: begin
          cnt_q <= '0;
          if (take) begin
            state_q <= req.write ? ST_WRITE : ST_READ;
          end else if (retain_s2_q) begin
            state_q <= ST_RETAIN;
          end
        end
        ST_WRITE: begin
          if (cnt_q >= sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::CYC_WRITE - 1)) begin
            state_q <= ST_WEND;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_WEND: begin
          state_q <= ST_IDLE;
        end
        ST_READ: begin
          if (cnt_q >= sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::CYC_READ + 1)) begin
            state_q <= ST_REND;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_REND: begin
          // Bus turnaround: the device may still drive for up to 20 ns.
          if (cnt_q >= sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::CYC_RELEASE - 1)) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_RETAIN: begin
          cnt_q <= '0;
          if (!retain_s2_q) begin
            state_q <= ST_RECOVER;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pin drivers
  // Write-low is set together with selection and released last, so the device never drives.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= sram_ctrl_pkg::CTRL_IDLE;
      word_address <= '0;
      data_out <= '0;
      data_oe <= '0;
    end else begin
      if (state_q == ST_IDLE && take) begin
        word_address <= req.addr;
        data_out <= req.wdata;
        ctrl.select_active_low <= 1'b0;
        ctrl.select_active_high <= 1'b1;
        ctrl.low_byte_enable_n <= ~req.lane_en[0];
        ctrl.upper_byte_enable_n <= ~req.lane_en[1];
        ctrl.read_write <= ~req.write;
        ctrl.output_enable_n <= req.write;
        data_oe <= req.write ? req.lane_en : '0;
      end else if (write_done) begin
        // Strobes end first; write-low and data stay one more clock.
        ctrl.select_active_low <= 1'b1;
        ctrl.select_active_high <= 1'b0;
        ctrl.low_byte_enable_n <= 1'b1;
        ctrl.upper_byte_enable_n <= 1'b1;
      end else if (state_q == ST_WEND) begin
        ctrl <= sram_ctrl_pkg::CTRL_IDLE;
        data_oe <= '0;
      end else if (read_done) begin
        ctrl <= sram_ctrl_pkg::CTRL_IDLE;
      end
    end
  end

  // ==========================================================================
  // Read lanes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lanes_q <= '0;
    end else if (take) begin
      lanes_q <= req.lane_en;
    end
  end

  // A disabled lane floats at the memory, so it reads back as zero rather than as noise.
  for (genvar lane = 0; lane < sram_ctrl_pkg::LANES; lane++) begin : g_lane_mask
    assign lane_mask[lane*sram_ctrl_pkg::LANE_W +: sram_ctrl_pkg::LANE_W] = {sram_ctrl_pkg::LANE_W{lanes_q[lane]}};
  end

  // ==========================================================================
  // Response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      // Sample while the strobes are still asserted, two clocks after data settled.
      rsp_valid <= read_done;
      if (read_done) begin
        rsp_rdata <= sync2_q & lane_mask;
      end
    end
  end

  // ==========================================================================
  // Handshake and status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
      retained <= 1'b0;
    end else begin
      // Ready drops once retention is pending; a request taken in that same edge is still served first.
      req_ready <= (state_q == ST_IDLE) && !take && !retain_s2_q;
      retained <= (state_q == ST_RETAIN);
    end
  end

endmodule // sram_host

// ==== test/sram_host_properties.sv ====
`timescale 1ns/1ps
module sram_host_properties #(
  parameter int RECOVERY_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic retained,
  input wire logic [17:0] word_address,
  input wire sram_ctrl_pkg::ctrl_s ctrl,
  input wire logic [1:0] data_oe
);
  logic sel, rd, wr_ov, rec_q;
  logic [1:0] lanes;
  int cnt_q;
  assign sel = !ctrl.select_active_low && ctrl.select_active_high;
  assign lanes = ~{ctrl.upper_byte_enable_n, ctrl.low_byte_enable_n};
  assign rd = sel && ctrl.read_write && !ctrl.output_enable_n;
  assign wr_ov = sel && !ctrl.read_write && (lanes != 2'h0);
  // A recovery is counted only after reset or retention, not after ordinary accesses.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_q <= 1'b1;
      cnt_q <= 0;
    end else begin
      rec_q <= retained | (rec_q & !req_ready);
      cnt_q <= (retained || req_ready) ? 0 : cnt_q + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_read_start;
    $fell(ctrl.output_enable_n) && rd;
  endsequence
  sequence s_read_done;
    ##3 rsp_valid;
  endsequence
  a_read_strobes: assert property (!ctrl.output_enable_n |-> sel && ctrl.read_write)
    else $error("read strobes wrong");
  a_read_answer: assert property (s_read_start |-> s_read_done)
    else $error("read answer late");
  a_no_contention: assert property (|data_oe |-> ctrl.output_enable_n && $past(ctrl.output_enable_n))
    else $error("drive while memory drives");
  a_addr_stable: assert property (sel && $past(sel) |-> $stable(word_address))
    else $error("address moved in cycle");
  a_write_select: assert property ($rose(wr_ov) |-> ##1 $fell(wr_ov) && !ctrl.read_write)
    else $error("write overlap length");
  a_write_lanes: assert property (wr_ov |-> data_oe == lanes)
    else $error("driven lanes differ");
  a_retain_idle: assert property (retained |-> !sel && !req_ready)
    else $error("access in retention");
  a_recovery_wait: assert property (rec_q && $rose(req_ready) |-> cnt_q >= RECOVERY_CYCLES)
    else $error("recovery too short");
endmodule // sram_host_properties
bind sram_host sram_host_properties #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_props (.clk, .rst_n,
  .req_ready, .rsp_valid, .retained, .word_address, .ctrl, .data_oe);

// ==== test/sram_device_model.sv ====
`timescale 1ns/1ps
module sram_device_model (
  // Memory pins
  input wire logic [17:0] word_address,
  input wire sram_ctrl_pkg::ctrl_s ctrl,
  input wire logic [15:0] data_out,
  input wire logic [1:0] data_oe,
  output logic [15:0] data_in
);
  logic [15:0] mem [0:262143];
  logic sel;
  logic [1:0] en, wr, drv;
  logic [15:0] q;
  assign sel = !ctrl.select_active_low && ctrl.select_active_high;
  assign en = ~{ctrl.upper_byte_enable_n, ctrl.low_byte_enable_n} & {2{sel}};
  assign wr = en & {2{!ctrl.read_write}};
  assign #20 drv = en & {2{ctrl.read_write && !ctrl.output_enable_n}};
  assign #10 q = mem[word_address];
  // A floating lane shows inverted data so a stale value never passes.
  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign data_in[i*8 +: 8] = (data_oe[i] && drv[i]) ? 8'hXX : data_oe[i] ? data_out[i*8 +: 8] :
      drv[i] ? q[i*8 +: 8] : ~q[i*8 +: 8];
    always @(negedge wr[i]) mem[word_address][i*8 +: 8] = data_out[i*8 +: 8];
  end
endmodule // sram_device_model

// ==== test/test_sram_host.sv ====
`timescale 1ns/1ps
module test_sram_host;
  logic clk, rst_n, req_valid, req_ready, rsp_valid, retain, retained;
  sram_ctrl_pkg::req_s req;
  sram_ctrl_pkg::ctrl_s ctrl;
  logic [15:0] rsp_rdata, data_in, data_out, q;
  logic [17:0] word_address;
  logic [1:0] data_oe;
  int fails, cmp_count;
  sram_host #(.RECOVERY_CYCLES(10)) u_dut (.clk, .rst_n, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp_rdata, .retain, .retained, .word_address, .ctrl, .data_in, .data_out, .data_oe);
  sram_device_model u_mem (.word_address, .ctrl, .data_out, .data_oe, .data_in);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] e);
    req = '{w, a, d, e};
    req_valid = 1'b1;
    for (int i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge clk);
    cmp("req_ready", 16'h0001, {15'h0000, req_ready});
    @(negedge clk);
    req_valid = 1'b0;
    for (int i = 0; i < 8 && !w && rsp_valid !== 1'b1; i++) @(negedge clk);
    q = rsp_rdata;
    if (!w) cmp("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_full();
    access(1'b1, 18'h3FFFF, 16'hA55A, 2'h3);
    access(1'b1, 18'h00000, 16'h1234, 2'h3);
    access(1'b0, 18'h3FFFF, 16'h0000, 2'h3);
    cmp("top word", 16'hA55A, q);
    access(1'b0, 18'h00000, 16'h0000, 2'h3);
    cmp("low word", 16'h1234, q);
  endtask
  task automatic t_lanes();
    access(1'b1, 18'h3FFFF, 16'h00C3, 2'h1);
    access(1'b1, 18'h3FFFF, 16'h7E11, 2'h2);
    access(1'b0, 18'h3FFFF, 16'h0000, 2'h3);
    cmp("lane merge", 16'h7EC3, q);
    access(1'b0, 18'h3FFFF, 16'h0000, 2'h2);
    cmp("upper lane read", 16'h7E00, q);
  endtask
  task automatic t_retain();
    retain = 1'b1;
    for (int i = 0; i < 10 && retained !== 1'b1; i++) @(negedge clk);
    cmp("retained", 16'h0001, {15'h0000, retained});
    cmp("ready held", 16'h0000, {15'h0000, req_ready});
    retain = 1'b0;
    access(1'b0, 18'h00000, 16'h0000, 2'h3);
    cmp("kept word", 16'h1234, q);
  endtask
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    retain = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_full();
    t_lanes();
    t_retain();
    give_verdict();
  end
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule // test_sram_host
